// ### inc/bomt_consts.svh
// constants for the bit-oriented message transceiver
// assumes inclusion by the package and the design module only
`ifndef BOMT_CONSTS_SVH
`define BOMT_CONSTS_SVH

// register offsets on the parallel processor port
`define BOMT_ADDR_CTRL      9'h0A0
`define BOMT_ADDR_TX_CW     9'h0A1
`define BOMT_ADDR_RX_CW     9'h0A2
`define BOMT_ADDR_STATUS    9'h0A3

// control register field positions
`define BOMT_CTRL_RX_SEARCH 7
`define BOMT_CTRL_RX_INTEG  6
`define BOMT_CTRL_RX_LEN_HI 5
`define BOMT_CTRL_RX_LEN_LO 4
`define BOMT_CTRL_TX_LEN_HI 3
`define BOMT_CTRL_TX_LEN_LO 2
`define BOMT_CTRL_MODE_HI   1
`define BOMT_CTRL_MODE_LO   0
`define BOMT_CTRL_RESET     8'h00

// received codeword and status field positions
`define BOMT_RX_LOST_BIT    7
`define BOMT_RX_VALID_BIT   6
`define BOMT_STAT_TX_ACTIVE 7
`define BOMT_STAT_RX_ACTIVE 6

// pattern layout and repetition counts
`define BOMT_PAT_LAST       4'hF
`define BOMT_PAT_FLAG_END   4'h7
`define BOMT_PAT_CW_FIRST   4'h9
`define BOMT_PAT_CW_LAST    4'hE
`define BOMT_REPS_LEN0      5'h01
`define BOMT_REPS_LEN1      5'h0A
`define BOMT_REPS_LEN2      5'h19

`endif

// ### inc/bomt_pkg.sv
// types for the bit-oriented message transceiver
// assumes the constants header sits in the include path
package bomt_pkg;
  `include "bomt_consts.svh"

  typedef enum logic [1:0] {
    BOMT_LEN_ONE  = 2'h0,
    BOMT_LEN_TEN  = 2'h1,
    BOMT_LEN_TWF  = 2'h2,
    BOMT_LEN_CONT = 2'h3
  } bomt_len_t;

  typedef enum {
    BOMT_TX_IDLE,
    BOMT_TX_WAIT,
    BOMT_TX_SEND
  } bomt_tx_state_t;
endpackage

// ### logic/bomt_transceiver.sv
// bit-oriented message transmitter and receiver on the facility data link
// assumes one link bit per i_link_bit_strobe pulse, slot chosen by link controller one
//
// Behaviour
// - a message is repeated 16-bit patterns, each holding one 6-bit codeword
// - the channel is link controller one's slot and bits; that controller runs
// - pattern sends eight ones, zero, six codeword bits, zero
// - receiver scans for patterns only while search enable is set
// - rx length 00 one, 01 ten, 10 twenty-five, 11 on change
// - change setting updates the received codeword on each different pattern
// - qualified message loads received codeword and pulses receive event together
// - gaps between patterns are allowed unless they hold a different codeword
// - codeword write sends 1, 10, 25 patterns or repeats forever
// - transmit event pulses at message start; software writes next after it
// - with nothing pending, the link returns to controller one output after a message
// - continuous message ends when software changes the tx length field
// - mode 0X disables and ignores writes, 10 message first, 11 controller first
// - message priority holds controller one off within eight bit times until done
// - controller one buffer writes stay possible while a message is sent
// - controller priority suspends message while its buffer is busy, resumes when idle
// - with controller priority, continuous message pauses at a pattern boundary when controller output waits
// - the transmitter works identically in E1 mode
// - codeword bit 0 goes out first, bit 5 sixth
// - valid flag sets on each codeword update, clears on read of received codeword
// - lost flag sets on update while valid still set
// - transmit active stays set for the whole message
`timescale 1ns/1ps
`include "bomt_consts.svh"
module bomt_transceiver
  import bomt_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cs,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [8:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  input  wire logic       i_link_bit_strobe,
  input  wire logic       i_link_rx_bit,
  input  wire logic       i_link_one_tx_bit,
  input  wire logic       i_link_one_buf_empty,
  input  wire logic       i_link_one_tx_idle,
  output logic            o_link_tx_bit,
  output logic            o_link_one_hold,
  output logic            o_tx_msg_event,
  output logic            o_rx_msg_event,
  output logic            o_tx_msg_active
);

  // repetition target for a length code; zero for change/continuous
  function automatic logic [4:0] reps_of(input logic [1:0] len);
    logic [4:0] r;
    r = 5'h00;
    unique case (bomt_len_t'(len))
      BOMT_LEN_ONE:  r = `BOMT_REPS_LEN0;
      BOMT_LEN_TEN:  r = `BOMT_REPS_LEN1;
      BOMT_LEN_TWF:  r = `BOMT_REPS_LEN2;
      BOMT_LEN_CONT: r = 5'h00;
    endcase
    return r;
  endfunction

  // register port decode
  logic       wr_ctrl;
  logic       wr_tx_cw;
  logic       rd_rx_cw;
  assign wr_ctrl  = i_cs && i_wr && (i_addr == `BOMT_ADDR_CTRL);
  assign wr_tx_cw = i_cs && i_wr && (i_addr == `BOMT_ADDR_TX_CW);
  assign rd_rx_cw = i_cs && i_rd && (i_addr == `BOMT_ADDR_RX_CW);

  logic [7:0] ctrl;
  logic       rx_search;
  logic [1:0] rx_len;
  logic [1:0] tx_len;
  logic [1:0] tx_mode;
  logic       tx_enabled;
  logic       msg_first;
  assign rx_search  = ctrl[`BOMT_CTRL_RX_SEARCH];
  assign rx_len     = ctrl[`BOMT_CTRL_RX_LEN_HI:`BOMT_CTRL_RX_LEN_LO];
  assign tx_len     = ctrl[`BOMT_CTRL_TX_LEN_HI:`BOMT_CTRL_TX_LEN_LO];
  assign tx_mode    = ctrl[`BOMT_CTRL_MODE_HI:`BOMT_CTRL_MODE_LO];
  assign tx_enabled = tx_mode[1];
  assign msg_first  = tx_enabled && !tx_mode[0];

  // ---------------- receiver state ----------------
  logic [15:0] rx_shift,  next_rx_shift;
  logic [5:0]  rx_last,   next_rx_last;
  logic        rx_have,   next_rx_have;
  logic [4:0]  rx_cnt,    next_rx_cnt;
  logic        rx_done,   next_rx_done;
  logic [5:0]  rx_cw,     next_rx_cw;
  logic        rx_valid,  next_rx_valid;
  logic        rx_lost,   next_rx_lost;
  logic        rx_active, next_rx_active;
  logic        next_rx_event;

  // pattern search and qualification
  always_comb begin
    logic        match;
    logic        same;
    logic        qualify;
    logic [5:0]  cw;
    logic [4:0]  target;
    logic [4:0]  cnt_n;
    match          = 1'b0;
    same           = 1'b0;
    qualify        = 1'b0;
    cw             = 6'h00;
    target         = reps_of(rx_len);
    cnt_n          = rx_cnt;
    next_rx_shift  = rx_shift;
    next_rx_last   = rx_last;
    next_rx_have   = rx_have;
    next_rx_cnt    = rx_cnt;
    next_rx_done   = rx_done;
    next_rx_cw     = rx_cw;
    next_rx_valid  = rx_valid && !rd_rx_cw;
    next_rx_lost   = rx_lost && !rd_rx_cw;
    next_rx_active = rx_active && !o_rx_msg_event;
    if (!rx_search) begin
      next_rx_shift  = 16'h0000;
      next_rx_have   = 1'b0;
      next_rx_cnt    = 5'h00;
      next_rx_done   = 1'b0;
      next_rx_active = 1'b0;
    end else if (i_link_bit_strobe) begin
      // first link bit lands lowest once sixteen bits are in
      next_rx_shift = {i_link_rx_bit, rx_shift[15:1]};
      match = (next_rx_shift[`BOMT_PAT_FLAG_END:0] == 8'hFF) && !next_rx_shift[8]
              && !next_rx_shift[15];
      cw    = next_rx_shift[`BOMT_PAT_CW_LAST:`BOMT_PAT_CW_FIRST];
    end
    if (match) begin
      // only a different valid codeword breaks a run
      same = rx_have && (cw == rx_last);
      if (bomt_len_t'(rx_len) == BOMT_LEN_CONT) begin
        qualify = !same;
      end else begin
        cnt_n   = !same ? 5'h01 : ((rx_cnt == target) ? rx_cnt : rx_cnt + 5'h01);
        qualify = (cnt_n == target) && !(same && rx_done);
      end
      next_rx_last   = cw;
      next_rx_have   = 1'b1;
      next_rx_cnt    = cnt_n;
      next_rx_done   = (same && rx_done) || qualify;
      next_rx_active = 1'b1;
    end
    if (qualify) begin
      next_rx_cw    = cw;
      next_rx_lost  = next_rx_lost || (rx_valid && !rd_rx_cw);
      next_rx_valid = 1'b1;
    end
    next_rx_event = qualify;
  end

  // receiver registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_shift       <= 16'h0000;
      rx_last        <= 6'h00;
      rx_have        <= 1'b0;
      rx_cnt         <= 5'h00;
      rx_done        <= 1'b0;
      rx_cw          <= 6'h00;
      rx_valid       <= 1'b0;
      rx_lost        <= 1'b0;
      rx_active      <= 1'b0;
      o_rx_msg_event <= 1'b0;
    end else begin
      rx_shift       <= next_rx_shift;
      rx_last        <= next_rx_last;
      rx_have        <= next_rx_have;
      rx_cnt         <= next_rx_cnt;
      rx_done        <= next_rx_done;
      rx_cw          <= next_rx_cw;
      rx_valid       <= next_rx_valid;
      rx_lost        <= next_rx_lost;
      rx_active      <= next_rx_active;
      o_rx_msg_event <= next_rx_event;
    end
  end

  // ---------------- transmitter state ----------------
  bomt_tx_state_t tx_state, next_tx_state;
  logic       tx_pend,   next_tx_pend;
  logic [5:0] tx_pcw,    next_tx_pcw;
  logic [5:0] tx_cw,     next_tx_cw;
  logic [1:0] tx_lenl,   next_tx_lenl;
  logic [3:0] tx_bit,    next_tx_bit;
  logic [4:0] tx_rep,    next_tx_rep;
  logic       next_tx_event;
  logic       next_link_tx_bit;
  logic       next_hold;

  // controller one has nothing queued and is idle
  logic       link_one_quiet;
  assign link_one_quiet = i_link_one_buf_empty && i_link_one_tx_idle;

  // message sequencing and link output selection
  always_comb begin
    logic       can_start;
    logic       pat_bit;
    logic       ended;
    logic [4:0] rep_n;
    pat_bit       = 1'b0;
    next_tx_state = tx_state;
    next_tx_pend  = tx_pend;
    next_tx_pcw   = tx_pcw;
    next_tx_cw    = tx_cw;
    next_tx_lenl  = tx_lenl;
    next_tx_bit   = tx_bit;
    next_tx_rep   = tx_rep;
    next_tx_event = 1'b0;
    rep_n         = tx_rep + 5'h01;
    ended         = 1'b0;
    // controller priority waits for an empty, idle controller
    can_start     = tx_enabled && tx_pend && (msg_first || link_one_quiet);
    // pattern bit: ones, zero, codeword low bit first, zero
    if (tx_bit <= `BOMT_PAT_FLAG_END) begin
      pat_bit = 1'b1;
    end else if (tx_bit >= `BOMT_PAT_CW_FIRST && tx_bit <= `BOMT_PAT_CW_LAST) begin
      pat_bit = tx_cw[3'(tx_bit - `BOMT_PAT_CW_FIRST)];
    end
    unique case (tx_state)
      BOMT_TX_IDLE: begin
        if (can_start) begin
          ended = 1'b1;                                 // start below
        end
      end
      BOMT_TX_WAIT: begin
        if (!tx_enabled) begin
          next_tx_state = BOMT_TX_IDLE;
        end else if (msg_first || link_one_quiet) begin
          next_tx_state = BOMT_TX_SEND;
        end
      end
      BOMT_TX_SEND: begin
        if (!tx_enabled) begin
          next_tx_state = BOMT_TX_IDLE;
        end else if (i_link_bit_strobe) begin
          next_tx_bit = tx_bit + 4'h1;
          if (tx_bit == `BOMT_PAT_LAST) begin
            next_tx_rep = rep_n;
            if (bomt_len_t'(tx_lenl) == BOMT_LEN_CONT) begin
              ended = (tx_len != tx_lenl);
            end else begin
              ended = (rep_n == reps_of(tx_lenl));
            end
            if (ended) begin
              next_tx_state = BOMT_TX_IDLE;
            end else if (!msg_first && !i_link_one_buf_empty) begin
              next_tx_state = BOMT_TX_WAIT;
            end
          end
        end
      end
    endcase
    // a message starts from idle or right behind the last one
    if (ended && can_start) begin
      next_tx_state = BOMT_TX_SEND;
      next_tx_cw    = tx_pcw;
      next_tx_lenl  = tx_len;
      next_tx_bit   = 4'h0;
      next_tx_rep   = 5'h00;
      next_tx_pend  = 1'b0;
      next_tx_event = 1'b1;
    end
    // writes are dropped while disabled; a new write wins over the take
    if (wr_tx_cw && tx_enabled) begin
      next_tx_pend = 1'b1;
      next_tx_pcw  = i_wdata[5:0];
    end
    // same pattern format on T1 and E1 links
    next_link_tx_bit = o_link_tx_bit;
    if (i_link_bit_strobe) begin
      next_link_tx_bit = (tx_state == BOMT_TX_SEND) ? pat_bit : i_link_one_tx_bit;
    end
    // controller one is held off, its buffer still writable
    next_hold = (next_tx_state == BOMT_TX_SEND);
  end

  // transmitter registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state        <= BOMT_TX_IDLE;
      tx_pend         <= 1'b0;
      tx_pcw          <= 6'h00;
      tx_cw           <= 6'h00;
      tx_lenl         <= 2'h0;
      tx_bit          <= 4'h0;
      tx_rep          <= 5'h00;
      o_tx_msg_event  <= 1'b0;
      o_link_tx_bit   <= 1'b1;
      o_link_one_hold <= 1'b0;
      o_tx_msg_active <= 1'b0;
    end else begin
      tx_state        <= next_tx_state;
      tx_pend         <= next_tx_pend;
      tx_pcw          <= next_tx_pcw;
      tx_cw           <= next_tx_cw;
      tx_lenl         <= next_tx_lenl;
      tx_bit          <= next_tx_bit;
      tx_rep          <= next_tx_rep;
      o_tx_msg_event  <= next_tx_event;
      o_link_tx_bit   <= next_link_tx_bit;
      o_link_one_hold <= next_hold;
      o_tx_msg_active <= (next_tx_state != BOMT_TX_IDLE);
    end
  end

  // ---------------- register file ----------------
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;

  // control write and read-back mux
  always_comb begin
    next_ctrl  = wr_ctrl ? i_wdata : ctrl;
    next_rdata = o_rdata;
    if (i_cs && i_rd) begin
      unique case (i_addr)
        `BOMT_ADDR_CTRL:   next_rdata = ctrl;
        `BOMT_ADDR_TX_CW:  next_rdata = {2'h0, tx_pcw};
        `BOMT_ADDR_RX_CW:  next_rdata = {rx_lost, rx_valid, rx_cw};
        `BOMT_ADDR_STATUS: next_rdata = {o_tx_msg_active, rx_active, 6'h00};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl    <= `BOMT_CTRL_RESET;
      o_rdata <= 8'h00;
    end else begin
      ctrl    <= next_ctrl;
      o_rdata <= next_rdata;
    end
  end

endmodule

// ### test/bomt_properties.sv
// port checker for the bit-oriented message transceiver
// assumes binding onto bomt_transceiver, one clock, async reset high
`timescale 1ns/1ps
module bomt_properties (
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_cs,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       i_link_bit_strobe,
  input wire logic       i_link_rx_bit,
  input wire logic       i_link_one_tx_bit,
  input wire logic       i_link_one_buf_empty,
  input wire logic       i_link_one_tx_idle,
  input wire logic       o_link_tx_bit,
  input wire logic       o_link_one_hold,
  input wire logic       o_tx_msg_event,
  input wire logic       o_rx_msg_event,
  input wire logic       o_tx_msg_active
);
  logic [7:0] ctrl;
  logic       cw_wr;
  // codeword write strobe
  assign cw_wr = i_cs && i_wr && (i_addr == 9'h0A1);
  // shadow of control register writes
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= 8'h00;
    end else if (i_cs && i_wr && (i_addr == 9'h0A0)) begin
      ctrl <= i_wdata;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_tx_ev_start: assert property ($rose(o_tx_msg_active) |-> o_tx_msg_event)
    else $error("tx event missing at message start");
  a_tx_ev_pulse: assert property (o_tx_msg_event |=> !o_tx_msg_event)
    else $error("tx event longer than one cycle");
  a_rx_ev_pulse: assert property (o_rx_msg_event |=> !o_rx_msg_event)
    else $error("rx event longer than one cycle");
  a_rx_ev_cause: assert property (o_rx_msg_event |-> $past(i_link_bit_strobe) && $past(ctrl[7]))
    else $error("rx event without strobe or search");
  a_hold_in_msg: assert property (o_link_one_hold |-> o_tx_msg_active)
    else $error("hold outside message");
  a_idle_follow: assert property ($past(i_link_bit_strobe) && !$past(o_tx_msg_active) && !o_tx_msg_active
    |-> o_link_tx_bit == $past(i_link_one_tx_bit)) else $error("link not following controller one");
  a_prio_start: assert property (cw_wr && ctrl[1:0] == 2'b10 && !o_tx_msg_active
    |-> ##2 (o_tx_msg_event && o_link_one_hold)) else $error("priority message late");
  a_off_ignore: assert property (cw_wr && !ctrl[1] && !o_tx_msg_active |=> !o_tx_msg_active [*4])
    else $error("disabled transmitter started");
  a_active_end: assert property ($fell(o_tx_msg_active)
    |-> $past(i_link_bit_strobe) || $past(i_cs && i_wr) || $past(i_cs && i_wr, 2)) else $error("active dropped early");
endmodule
bind bomt_transceiver bomt_properties i_bomt_properties (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs(i_cs),
  .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .i_link_bit_strobe(i_link_bit_strobe), .i_link_rx_bit(i_link_rx_bit), .i_link_one_tx_bit(i_link_one_tx_bit),
  .i_link_one_buf_empty(i_link_one_buf_empty), .i_link_one_tx_idle(i_link_one_tx_idle),
  .o_link_tx_bit(o_link_tx_bit), .o_link_one_hold(o_link_one_hold), .o_tx_msg_event(o_tx_msg_event),
  .o_rx_msg_event(o_rx_msg_event), .o_tx_msg_active(o_tx_msg_active));

// ### test/bomt_link_partner.sv
// far-end link model: bit strobe, received patterns, controller one, capture
// assumes the bench drives codeword, send and busy at falling edges
`timescale 1ns/1ps
module bomt_link_partner (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [5:0]  i_cw,
  input  wire logic        i_send,
  input  wire logic        i_busy,
  input  wire logic        i_tx_bit,
  output logic             o_strobe,
  output logic             o_rx_bit,
  output logic             o_l1_bit,
  output logic             o_buf_empty,
  output logic             o_tx_idle,
  output logic [15:0]      o_cap,
  output logic [7:0]       o_pats
);
  logic [1:0] cnt;
  logic [3:0] pi;
  logic       sending;
  // controller one set up and running on the slot
  assign o_buf_empty = !i_busy;
  assign o_tx_idle   = !i_busy;
  // strobe every fourth cycle, pattern or filler, capture two cycles later
  always @(negedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt      <= 2'h0;
      pi       <= 4'h0;
      sending  <= 1'b0;
      o_strobe <= 1'b0;
      o_rx_bit <= 1'b0;
      o_l1_bit <= 1'b0;
      o_cap    <= 16'h0000;
      o_pats   <= 8'h00;
    end else begin
      cnt      <= cnt + 2'h1;
      o_strobe <= (cnt == 2'h3);
      if (cnt == 2'h1) begin
        o_cap <= {i_tx_bit, o_cap[15:1]}; // first sent bit lands in bit 0
      end
      if (cnt == 2'h3) begin
        o_l1_bit <= ~o_l1_bit;
        if (sending || i_send) begin
          o_rx_bit <= (pi < 4'h8) ? 1'b1 : (pi == 4'h8 || pi == 4'hF) ? 1'b0 : i_cw[pi - 4'h9];
          pi       <= pi + 4'h1;
          sending  <= (pi != 4'hF) || i_send;
          if (pi == 4'hF) begin
            o_pats <= o_pats + 8'h01;
          end
        end else begin
          o_rx_bit <= ~o_rx_bit; // filler never holds eight ones
        end
      end
    end
  end
endmodule

// ### test/bit_oriented_msg_transceiver_tb.sv
// self-checking bench for the message transceiver
// assumes the link partner model and the bound port checker
`timescale 1ns/1ps
module bit_oriented_msg_transceiver_tb;
  logic        clk = 1'b0, rst = 1'b1, cs = 1'b0, wr = 1'b0, rd = 1'b0, send = 1'b0, busy = 1'b0;
  logic [8:0]  addr = 9'h000;
  logic [7:0]  wdata = 8'h00, rdata, pats;
  logic [5:0]  cw = 6'h00;
  logic        strobe, rxb, l1b, bempty, tidle, txb, hold, tev, rev, act;
  logic [15:0] cap;
  int          err_count = 0, samples_checked = 0, n;
  bit          hit;
  // clock
  always #5 clk = ~clk;
  bomt_transceiver i_bomt_transceiver (.i_sys_clk(clk), .i_rst(rst), .i_cs(cs), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_link_bit_strobe(strobe), .i_link_rx_bit(rxb),
    .i_link_one_tx_bit(l1b), .i_link_one_buf_empty(bempty), .i_link_one_tx_idle(tidle), .o_link_tx_bit(txb),
    .o_link_one_hold(hold), .o_tx_msg_event(tev), .o_rx_msg_event(rev), .o_tx_msg_active(act));
  bomt_link_partner i_bomt_link_partner (.i_sys_clk(clk), .i_rst(rst), .i_cw(cw), .i_send(send), .i_busy(busy),
    .i_tx_bit(txb), .o_strobe(strobe), .o_rx_bit(rxb), .o_l1_bit(l1b), .o_buf_empty(bempty), .o_tx_idle(tidle),
    .o_cap(cap), .o_pats(pats));
  // verdict and end of run
  task conclude;
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // value compare
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // register cycles, driven at falling edges
  task wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    cs = 1'b1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    cs = 1'b0;
    wr = 1'b0;
  endtask
  task rd_chk(input string what, input logic [8:0] a, input logic [7:0] e);
    @(negedge clk);
    cs = 1'b1;
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    cs = 1'b0;
    rd = 1'b0;
    @(negedge clk);
    chk(what, e, rdata);
  endtask
  // bounded wait: 0 tx event, 1 rx event, 2 inactive, 3 hold low, 4 hold high
  task wait_for(input int sel, input int lim);
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++) begin
      @(posedge clk);
      #1;
      hit = sel == 0 ? tev === 1'b1 : sel == 1 ? rev === 1'b1 : sel == 2 ? act === 1'b0 : hold === (sel == 4);
    end
  endtask
  task need(input int sel, input int lim);
    wait_for(sel, lim);
    if (!hit) begin
      err_count++;
      $display("MISMATCH wait %0d expected 1 seen 0", sel);
      conclude;
    end
  endtask
  task cap_chk(input logic [5:0] c);
    repeat (2) @(negedge clk); // far end takes the last bit two cycles after its strobe
    #1;
    chk("sent pattern", {1'b0, c, 1'b0, 8'hFF}, cap);
  endtask
  task reg_reset;
    rd_chk("ctrl", 9'h0A0, 8'h00);
    rd_chk("status", 9'h0A3, 8'h00);
    rd_chk("rx cw", 9'h0A2, 8'h00);
    rd_chk("unmapped", 9'h0B0, 8'h00);
    wr_reg(9'h0A0, 8'hC6);
    rd_chk("ctrl rw", 9'h0A0, 8'hC6);
  endtask
  task rx_run(input logic [5:0] c, input logic [1:0] len, input logic srch, input int exp);
    int base;
    wr_reg(9'h0A0, {srch, 1'b0, len, 4'h0});
    base = pats;
    cw = c;
    send = 1'b1;
    wait_for(1, exp * 64 + 80);
    chk("rx event", exp != 0, hit);
    if (hit) chk("rx patterns", exp, pats - base);
    @(negedge clk);
    send = 1'b0;
    repeat (80) @(negedge clk);
  endtask
  task tx_msg(input logic [5:0] c, input logic [1:0] len, input int reps);
    wr_reg(9'h0A0, {4'h0, len, 2'b10});
    wr_reg(9'h0A1, {2'b00, c}); // controller one idle beforehand
    need(0, 10);
    need(2, reps * 64 + 20);
    chk("tx patterns", reps, (n + 8) / 64);
    cap_chk(c);
    rd_chk("tx cw", 9'h0A1, {2'b00, c});
  endtask
  task tx_b2b;
    wr_reg(9'h0A0, 8'h02);
    wr_reg(9'h0A1, 8'h15);
    need(0, 10);
    wr_reg(9'h0A1, 8'h2A);
    need(0, 100);
    chk("no gap", 1'b1, act);
    need(2, 100);
    chk("second patterns", 1, (n + 8) / 64);
    cap_chk(6'h2A);
  endtask
  task tx_cont;
    wr_reg(9'h0A0, 8'h0E);
    wr_reg(9'h0A1, 8'h3C);
    need(0, 10);
    rd_chk("status", 9'h0A3, 8'h80);
    repeat (300) @(negedge clk);
    chk("cont active", 1'b1, act);
    wr_reg(9'h0A0, 8'h02);
    need(2, 80);
    cap_chk(6'h3C);
  endtask
  task tx_yield;
    busy = 1'b1;
    wr_reg(9'h0A0, 8'h0F);
    wr_reg(9'h0A1, 8'h09);
    wait_for(0, 200);
    chk("held off", 1'b0, hit);
    @(negedge clk);
    busy = 1'b0;
    need(0, 20);
    repeat (100) @(negedge clk);
    busy = 1'b1;
    need(3, 80);
    chk("paused active", 1'b1, act);
    @(negedge clk);
    busy = 1'b0;
    need(4, 20);
    wr_reg(9'h0A0, 8'h03);
    need(2, 150);
  endtask
  task tx_off;
    for (int m = 0; m < 2; m++) begin
      wr_reg(9'h0A0, m[7:0]);
      wr_reg(9'h0A1, 8'h2A);
      wait_for(0, 20);
      chk("ignored", 1'b0, hit);
    end
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    reg_reset;
    rx_run(6'h11, 2'b00, 1'b0, 0);
    rx_run(6'h12, 2'b00, 1'b1, 1);
    rx_run(6'h2D, 2'b01, 1'b1, 10);
    rd_chk("lost", 9'h0A2, 8'hED);
    rd_chk("cleared", 9'h0A2, 8'h2D);
    rx_run(6'h07, 2'b10, 1'b1, 25);
    rx_run(6'h38, 2'b11, 1'b1, 1);
    rd_chk("change cw", 9'h0A2, 8'hF8);
    tx_off;
    tx_msg(6'h0B, 2'b00, 1);
    tx_msg(6'h21, 2'b01, 10);
    tx_msg(6'h34, 2'b10, 25);
    tx_b2b;
    tx_cont;
    tx_yield;
    conclude;
  end
endmodule
